//--- rtl/cmc_map.vh
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
`define CMC_REG_OUTPUT_VOLTAGE_SETPOINT 8'h00
`define CMC_REG_CFGA 8'h01
`define CMC_REG_CFGB 8'h02
`define CMC_REG_CFGC 8'h03
`define CMC_REG_FLT 8'h04
`define CMC_RST_CFGA 8'h2A
`define CMC_RST_CFGB 8'h09
`define CMC_RST_CFGC 8'h00
`define CMC_BIT_RESET 7
`define CMC_BIT_SWITCHING_SOFT_ENABLE 5
`define CMC_BIT_SINGLE 0
`define CMC_CFGB_MASK 8'h0F
`define CMC_CFGC_MASK 8'h03
`define CMC_INIT_US 400
`define CMC_CLK_MHZ 100
`define CMC_ENDLY_US 400
`define CMC_ADDR_UPPER 3'h4
`endif

//--- rtl/cmc_sync2.v
`timescale 1ns/100ps
// Two-stage synchroniser; only the second stage leaves this module.
module cmc_sync2 #(
    parameter W = 1
) (
    input wire clk_in,
    input wire srst_in,
    input wire [W-1:0] d_in,
    input wire [W-1:0] rst_val_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] meta_q;
    always @(posedge clk_in) begin
        // Reset to each input's idle level, so no false edge follows reset.
        if (srst_in) begin
            meta_q <= rst_val_in;
            q_out <= rst_val_in;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule

//--- rtl/cmc_regfile.v
`timescale 1ns/100ps
`include "cmc_map.vh"
// Byte register file; read data come out of a register.
module cmc_regfile (
    input wire clk_in,
    input wire clear_in,
    input wire [7:0] output_voltage_setpoint_rst_in,
    input wire wr_in,
    input wire [7:0] waddr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] raddr_in,
    input wire [7:0] status_in,
    output reg [7:0] rdata_out,
    output reg [7:0] output_voltage_setpoint_out,
    output reg [7:0] cfga_out,
    output reg [7:0] cfgb_out,
    output reg [7:0] cfgc_out
);
    always @(posedge clk_in) begin
        if (clear_in) begin
            output_voltage_setpoint_out <= output_voltage_setpoint_rst_in;
            cfga_out <= `CMC_RST_CFGA;
            cfgb_out <= `CMC_RST_CFGB;
            cfgc_out <= `CMC_RST_CFGC;
        end else if (wr_in) begin
            if (waddr_in == `CMC_REG_OUTPUT_VOLTAGE_SETPOINT) begin
                output_voltage_setpoint_out <= wdata_in;
            end else if (waddr_in == `CMC_REG_CFGA) begin
                cfga_out <= wdata_in & 8'h7F;
            end else if (waddr_in == `CMC_REG_CFGB) begin
                cfgb_out <= wdata_in & `CMC_CFGB_MASK;
            end else if (waddr_in == `CMC_REG_CFGC) begin
                cfgc_out <= wdata_in & `CMC_CFGC_MASK;
            end
        end
    end

    always @(posedge clk_in) begin
        if (clear_in) begin
            rdata_out <= 8'h00;
        end else if (raddr_in == `CMC_REG_OUTPUT_VOLTAGE_SETPOINT) begin
            rdata_out <= output_voltage_setpoint_out;
        end else if (raddr_in == `CMC_REG_CFGA) begin
            rdata_out <= cfga_out;
        end else if (raddr_in == `CMC_REG_CFGB) begin
            rdata_out <= cfgb_out;
        end else if (raddr_in == `CMC_REG_CFGC) begin
            rdata_out <= cfgc_out;
        end else if (raddr_in == `CMC_REG_FLT) begin
            rdata_out <= status_in;
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule

//--- rtl/cmc_top.v
`timescale 1ns/100ps
`include "cmc_map.vh"
// Behaviour
// - Below reset threshold, nothing works, registers invalid.
// - Above reset threshold, move to lockout mode.
// - Lockout keeps registers; discharge only if lockout was entered from standby or on.
// - Lockout exits to reset or standby by supply.
// - First lockout exit runs init, samples straps.
// - Lockout dip without reset skips initialization.
// - Any disable condition keeps device in standby.
// - Standby keeps bus and discharge; no switching.
// - All enable conditions move standby to on.
// - On exits to lockout or standby promptly.
// - Lockout, overvoltage, overtemperature pull shared enable low.
// - Current limit keeps enable high, clamps amplifier.
// - Target only, up to one megabit.
// - Seven-bit addressing, general call ignored.
// - Address low bits come from voltage strap.
// - Registers kept while above reset threshold, except on a reset-bit write.
// - Acknowledge held low through ninth clock high.
// - Direction bit picks write or read; unlimited bytes.
// - Write commits at falling edge after data ack.
// - After stop, ignore bus until start and address.
// - Unmapped register reads return zero.
// - Reset bit restores defaults, restarts, delays writes.
// - Soft enable resets high, acts without delay.
// - Reset bit always reads zero.
module cmc_top #(
    parameter INIT_CYCLES = `CMC_INIT_US * `CMC_CLK_MHZ,
    parameter ENDLY_CYCLES = `CMC_ENDLY_US * `CMC_CLK_MHZ,
    parameter [7:0] OUTPUT_VOLTAGE_SETPOINT_DEFAULT = 8'h00
) (
    input wire clk_in,
    input wire srst_in,
    input wire above_por_in,
    input wire above_uvlo_in,
    input wire above_ovlo_in,
    input wire over_temp_in,
    input wire cur_limit_in,
    input wire en_pin_in,
    input wire [1:0] voltage_select_strap_in,
    input wire [1:0] frequency_select_strap_in,
    input wire sync_out_strap_in,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n_out,
    output wire en_pull_low_out,
    output reg switching_out,
    output reg discharge_avail_out,
    output reg iface_active_out,
    output reg amp_clamp_out,
    output reg softstart_out,
    output reg [2:0] mode_out,
    output reg [1:0] freq_sel_out,
    output reg secondary_out,
    output wire [7:0] output_voltage_setpoint_out,
    output wire [7:0] cfga_out,
    output wire [7:0] cfgb_out,
    output wire [7:0] cfgc_out
);
    localparam M_POR = 3'd0;
    localparam M_UVLO = 3'd1;
    localparam M_INIT = 3'd2;
    localparam M_STBY = 3'd3;
    localparam M_ON = 3'd4;

    localparam B_IDLE = 3'd0;
    localparam B_ADDR = 3'd1;
    localparam B_AACK = 3'd2;
    localparam B_WBYTE = 3'd3;
    localparam B_WACK = 3'd4;
    localparam B_RBYTE = 3'd5;
    localparam B_RACK = 3'd6;

    // Asynchronous supply and pin levels are synchronised first.
    wire [8:0] raw_w = {above_por_in, above_uvlo_in, above_ovlo_in,
        over_temp_in, cur_limit_in, en_pin_in, sync_out_strap_in,
        scl_in, sda_in};
    wire [8:0] syn_w;
    wire [3:0] strap_w;
    cmc_sync2 #(.W(9)) u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in(raw_w),
        .rst_val_in(9'h003),
        .q_out(syn_w)
    );
    cmc_sync2 #(.W(4)) u_sync_strap (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in({voltage_select_strap_in, frequency_select_strap_in}),
        .rst_val_in(4'h0),
        .q_out(strap_w)
    );
    wire por_ok = syn_w[8];
    wire uv_ok = syn_w[7];
    wire ov = syn_w[6];
    wire ot = syn_w[5];
    wire ilim = syn_w[4];
    wire en_s = syn_w[3];
    wire scl_s = syn_w[1];
    wire sda_s = syn_w[0];

    reg [2:0] mode_q;
    reg from_stby_q;
    reg [31:0] cnt_q;
    reg [1:0] voltage_select_strap_q;
    reg [31:0] wdly_q;
    reg sw_rst_q;
    reg was_on_q;
    reg fault_cause_q;

    wire switching_soft_enable = cfga_out[`CMC_BIT_SWITCHING_SOFT_ENABLE];
    wire single = cfgc_out[`CMC_BIT_SINGLE];
    wire go_on = en_s & switching_soft_enable & ~ot & ~ov;
    wire fault_any = ~uv_ok | ov | ot;

    function [7:0] sh_in;
        input [7:0] v;
        input b;
        begin
            sh_in = {v[6:0], b};
        end
    endfunction

    // Operating-mode machine.
    always @(posedge clk_in) begin
        if (srst_in) begin
            mode_q <= M_POR;
            from_stby_q <= 1'b0;
            cnt_q <= 32'd0;
        end else if (!por_ok) begin
            mode_q <= M_POR;
            from_stby_q <= 1'b0;
        end else begin
            case (mode_q)
                M_POR: begin
                    mode_q <= M_UVLO;
                    from_stby_q <= 1'b0;
                    cnt_q <= 32'd0;
                end
                M_UVLO: begin
                    if (uv_ok) begin
                        cnt_q <= 32'd0;
                        if (from_stby_q) begin
                            mode_q <= M_STBY;
                        end else begin
                            mode_q <= M_INIT;
                        end
                    end
                end
                M_INIT: begin
                    if (!uv_ok) begin
                        mode_q <= M_UVLO;
                    end else if (cnt_q >= INIT_CYCLES - 1) begin
                        mode_q <= M_STBY;
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                M_STBY: begin
                    if (sw_rst_q) begin
                        mode_q <= M_INIT;
                        cnt_q <= 32'd0;
                    end else if (!uv_ok) begin
                        mode_q <= M_UVLO;
                        from_stby_q <= 1'b1;
                    end else if (go_on) begin
                        mode_q <= M_ON;
                    end
                end
                default: begin
                    if (sw_rst_q) begin
                        mode_q <= M_INIT;
                        cnt_q <= 32'd0;
                    end else if (!uv_ok) begin
                        mode_q <= M_UVLO;
                        from_stby_q <= 1'b1;
                    end else if (!go_on) begin
                        mode_q <= M_STBY;
                    end
                end
            endcase
        end
    end

    // Straps are caught on the first cycle of initialization.
    always @(posedge clk_in) begin
        if (srst_in) begin
            voltage_select_strap_q <= 2'd0;
            freq_sel_out <= 2'd0;
            secondary_out <= 1'b0;
        end else if (mode_q == M_INIT && cnt_q == 32'd0) begin
            voltage_select_strap_q <= strap_w[3:2];
            freq_sel_out <= strap_w[1:0];
            secondary_out <= ~syn_w[2];
        end
    end

    // Mode decoded outputs; a fresh entry to on mode starts soft start.
    always @(posedge clk_in) begin
        if (srst_in) begin
            switching_out <= 1'b0;
            discharge_avail_out <= 1'b0;
            iface_active_out <= 1'b0;
            amp_clamp_out <= 1'b0;
            softstart_out <= 1'b0;
            mode_out <= M_POR;
            was_on_q <= 1'b0;
            fault_cause_q <= 1'b0;
        end else begin
            mode_out <= mode_q;
            was_on_q <= (mode_q == M_ON);
            switching_out <= (mode_q == M_ON);
            discharge_avail_out <= cfga_out[3] & ((mode_q == M_STBY) |
                (mode_q == M_UVLO & from_stby_q));
            iface_active_out <= (mode_q == M_STBY) | (mode_q == M_ON);
            amp_clamp_out <= (mode_q == M_ON) & ilim;
            softstart_out <= (mode_q == M_ON) & ~was_on_q;
            fault_cause_q <= ~single & (mode_q != M_POR) & fault_any;
        end
    end
    // Current limit is left out here so the shared line stays high.
    assign en_pull_low_out = fault_cause_q | (mode_q == M_INIT);

    // Target state; the strap fixes the address low bits.
    reg [2:0] bst_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [7:0] ptr_q;
    reg have_ptr_q;
    reg sda_drv_q;
    reg scl_prev_q;
    reg sda_prev_q;
    reg wr_q;
    reg [7:0] wdat_q;
    wire [7:0] rdata_w;
    wire [6:0] my_addr = {`CMC_ADDR_UPPER, 2'b00, voltage_select_strap_q};
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    wire wr_ok = (wdly_q == 32'd0);

    always @(posedge clk_in) begin
        if (srst_in || !iface_active_out) begin
            bst_q <= B_IDLE;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            have_ptr_q <= 1'b0;
            sda_drv_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            wr_q <= 1'b0;
            wdat_q <= 8'h00;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            wr_q <= 1'b0;
            if (stop_c) begin
                bst_q <= B_IDLE;
                sda_drv_q <= 1'b0;
            end else if (start_c) begin
                bst_q <= B_ADDR;
                bit_q <= 4'd0;
                have_ptr_q <= 1'b0;
                sda_drv_q <= 1'b0;
            end else begin
                case (bst_q)
                    B_ADDR, B_WBYTE: begin
                        if (scl_rise) begin
                            sh_q <= sh_in(sh_q, sda_s);
                            bit_q <= bit_q + 4'd1;
                        end else if (scl_fall && bit_q == 4'd8) begin
                            bit_q <= 4'd0;
                            if (bst_q == B_WBYTE) begin
                                sda_drv_q <= 1'b1;
                                bst_q <= B_WACK;
                            end else if (sh_q[7:1] == my_addr) begin
                                sda_drv_q <= 1'b1;
                                bst_q <= B_AACK;
                            end else begin
                                bst_q <= B_IDLE;
                            end
                        end
                    end
                    B_AACK: begin
                        if (scl_fall) begin
                            if (sh_q[0]) begin
                                bst_q <= B_RBYTE;
                                sh_q <= rdata_w;
                                sda_drv_q <= ~rdata_w[7];
                                ptr_q <= ptr_q + 8'd1;
                            end else begin
                                bst_q <= B_WBYTE;
                                sda_drv_q <= 1'b0;
                            end
                        end
                    end
                    B_WACK: begin
                        // Hold low until ninth clock falls.
                        if (scl_fall) begin
                            sda_drv_q <= 1'b0;
                            bst_q <= B_WBYTE;
                            if (!have_ptr_q) begin
                                ptr_q <= sh_q;
                                have_ptr_q <= 1'b1;
                            end else begin
                                wr_q <= wr_ok;
                                wdat_q <= sh_q;
                                ptr_q <= ptr_q + 8'd1;
                            end
                        end
                    end
                    B_RBYTE: begin
                        if (scl_fall) begin
                            if (bit_q == 4'd7) begin
                                bit_q <= 4'd0;
                                sda_drv_q <= 1'b0;
                                bst_q <= B_RACK;
                            end else begin
                                bit_q <= bit_q + 4'd1;
                                sh_q <= sh_in(sh_q, 1'b0);
                                sda_drv_q <= ~sh_q[6];
                            end
                        end
                    end
                    B_RACK: begin
                        if (scl_rise && sda_s) begin
                            bst_q <= B_IDLE;
                        end else if (scl_fall) begin
                            bst_q <= B_RBYTE;
                            sh_q <= rdata_w;
                            sda_drv_q <= ~rdata_w[7];
                            ptr_q <= ptr_q + 8'd1;
                        end
                    end
                    default: begin
                        sda_drv_q <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~sda_drv_q;

    // A reset-bit write clears registers and blocks writes for a while.
    wire wr_is_rst = wr_q && ptr_q == `CMC_REG_CFGA + 8'd1 &&
        wdat_q[`CMC_BIT_RESET];
    always @(posedge clk_in) begin
        if (srst_in) begin
            sw_rst_q <= 1'b0;
            wdly_q <= 32'd0;
        end else begin
            sw_rst_q <= wr_is_rst;
            if (wr_is_rst) begin
                wdly_q <= ENDLY_CYCLES;
            end else if (wdly_q != 32'd0) begin
                wdly_q <= wdly_q - 32'd1;
            end
        end
    end

    // Registers only clear on srst_in, below the reset threshold or on a reset bit.
    wire rf_clear = srst_in | (mode_q == M_POR) | sw_rst_q;
    cmc_regfile u_rf (
        .clk_in(clk_in),
        .clear_in(rf_clear),
        .output_voltage_setpoint_rst_in(OUTPUT_VOLTAGE_SETPOINT_DEFAULT),
        .wr_in(wr_q & ~wr_is_rst),
        .waddr_in(ptr_q - 8'd1),
        .wdata_in(wdat_q),
        .raddr_in(ptr_q),
        .status_in({5'd0, ilim, ot, ~uv_ok}),
        .rdata_out(rdata_w),
        .output_voltage_setpoint_out(output_voltage_setpoint_out),
        .cfga_out(cfga_out),
        .cfgb_out(cfgb_out),
        .cfgc_out(cfgc_out)
    );
endmodule

//--- verif/cmc_top_sva.sv
`timescale 1ns/100ps
module cmc_top_sva (
    input wire clk_in,
    input wire srst_in,
    input wire above_por_in,
    input wire above_uvlo_in,
    input wire above_ovlo_in,
    input wire over_temp_in,
    input wire cur_limit_in,
    input wire en_pin_in,
    input wire scl_in,
    input wire sda_oe_n_out,
    input wire en_pull_low_out,
    input wire switching_out,
    input wire amp_clamp_out,
    input wire softstart_out,
    input wire [2:0] mode_out,
    input wire [7:0] cfga_out,
    input wire [7:0] cfgc_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // Windows allow for the input synchronisers plus one mode step.
    sequence s_por_lost;
        (!above_por_in) [*8];
    endsequence
    sequence s_uvlo_lost;
        (above_por_in && !above_uvlo_in) [*8];
    endsequence
    sequence s_scl_high;
        scl_in [*2];
    endsequence
    AST_POR_MODE: assert property (s_por_lost |-> mode_out == 3'h0)
        else $error("mode not reset after supply loss");
    AST_UVLO_MODE: assert property (s_uvlo_lost |-> mode_out == 3'h1)
        else $error("mode not lockout with low supply");
    AST_STBY_NO_SW: assert property ((mode_out == 3'h3) [*2] |-> !switching_out)
        else $error("switching in standby");
    AST_OFF_COND: assert property ((!en_pin_in || over_temp_in || above_ovlo_in || !cfga_out[5]) [*6] |-> mode_out != 3'h4)
        else $error("on mode with a standby condition");
    AST_SOFTSTART: assert property ($rose(mode_out == 3'h4) |-> ##[0:1] softstart_out)
        else $error("no soft start on entry to on");
    AST_FAULT_PULL: assert property ((mode_out == 3'h3 && !cfgc_out[0] && (over_temp_in || above_ovlo_in)) [*6] |-> en_pull_low_out)
        else $error("fault did not pull enable low");
    AST_CUR_LIMIT: assert property ((cur_limit_in && mode_out == 3'h4) [*6] |-> amp_clamp_out && !en_pull_low_out)
        else $error("current limit response wrong");
    AST_SDA_STABLE: assert property (s_scl_high |-> $stable(sda_oe_n_out))
        else $error("sda drive changed while scl high");
    AST_BUS_IDLE: assert property ((mode_out < 3'h3) [*2] |-> sda_oe_n_out)
        else $error("bus driven before standby");
endmodule
bind cmc_top cmc_top_sva u_sva (.clk_in(clk_in), .srst_in(srst_in),
    .above_por_in(above_por_in), .above_uvlo_in(above_uvlo_in),
    .above_ovlo_in(above_ovlo_in), .over_temp_in(over_temp_in),
    .cur_limit_in(cur_limit_in), .en_pin_in(en_pin_in), .scl_in(scl_in),
    .sda_oe_n_out(sda_oe_n_out), .en_pull_low_out(en_pull_low_out),
    .switching_out(switching_out), .amp_clamp_out(amp_clamp_out),
    .softstart_out(softstart_out), .mode_out(mode_out),
    .cfga_out(cfga_out), .cfgc_out(cfgc_out));

//--- verif/cmc_i2c_ctrl.sv
`timescale 1ns/100ps
// Bus controller model; SCL stands high between frames.
module cmc_i2c_ctrl (
    input wire sda_in,
    output reg scl_out,
    output reg sda_rel_out
);
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    // A high seen at either end of the high phase counts, so a short ack fails.
    task bit_io(input b, output r);
    begin
        sda_rel_out = b;
        #40 scl_out = 1'b1;
        #2 r = sda_in;
        #76 r = r | sda_in;
        #2 scl_out = 1'b0;
        #40;
    end
    endtask
    task bus_start;
    begin
        sda_rel_out = 1'b1;
        #40 scl_out = 1'b1;
        #80 sda_rel_out = 1'b0;
        #80 scl_out = 1'b0;
        #40;
    end
    endtask
    // SCL and SDA go low at the same instant, so a stop sent from idle is never seen as a start.
    task bus_stop;
    begin
        scl_out = 1'b0;
        sda_rel_out = 1'b0;
        #40 scl_out = 1'b1;
        #80 sda_rel_out = 1'b1;
        #80;
    end
    endtask
    task wbyte(input [7:0] b, output ack);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    end
    endtask
    task rbyte(input nack, output [7:0] b);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(1'b1, b[i]);
        bit_io(nack, r);
    end
    endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam [7:0] AW = 8'h84;
    reg clk_in = 1'b0;
    reg srst_in = 1'b1;
    reg por = 1'b0, uvlo = 1'b0, ovlo = 1'b0, ot = 1'b0, cl = 1'b0;
    reg en_ext = 1'b0;
    reg ack, saw_init, saw_sst;
    reg [7:0] init_len = 8'h00;
    reg [7:0] rv;
    integer failures = 0, num_checks = 0, k;
    wire scl, sda_rel, sda_out, sda_oe_n, en_pull, sw, dis, clamp;
    wire [2:0] mode;
    wire [1:0] frequency_select_strap_q;
    wire sec, iface, sst;
    wire [7:0] output_voltage_setpoint, cfga, cfgb, cfgc;
    wire sda = sda_rel & (sda_oe_n | sda_out);
    wire en_pin = en_ext & !en_pull;
    cmc_top #(.INIT_CYCLES(20), .ENDLY_CYCLES(1000)) dut (
        .clk_in(clk_in), .srst_in(srst_in), .above_por_in(por),
        .above_uvlo_in(uvlo), .above_ovlo_in(ovlo), .over_temp_in(ot),
        .cur_limit_in(cl), .en_pin_in(en_pin),
        .voltage_select_strap_in(2'h2), .frequency_select_strap_in(2'h1),
        .sync_out_strap_in(1'b0), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
        .en_pull_low_out(en_pull), .switching_out(sw),
        .discharge_avail_out(dis), .iface_active_out(iface),
        .amp_clamp_out(clamp), .softstart_out(sst), .mode_out(mode),
        .freq_sel_out(frequency_select_strap_q),
        .secondary_out(sec), .output_voltage_setpoint_out(output_voltage_setpoint), .cfga_out(cfga),
        .cfgb_out(cfgb), .cfgc_out(cfgc));
    cmc_i2c_ctrl u_ctl (.sda_in(sda), .scl_out(scl), .sda_rel_out(sda_rel));
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (mode === 3'h2) begin
            saw_init <= 1'b1;
            init_len <= init_len + 8'h01;
        end
        if (sst === 1'b1) saw_sst <= 1'b1;
    end
    task check(input [7:0] seen, input [7:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge clk_in);
        #1;
    end
    endtask
    task wait_mode(input [2:0] m);
        integer i;
    begin
        for (i = 0; i < 3000 && mode !== m; i = i + 1)
            tick(1);
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg a1, a2;
    begin
        u_ctl.bus_start;
        u_ctl.wbyte(AW, a1);
        u_ctl.wbyte(a, a2);
        u_ctl.wbyte(d, ack);
        u_ctl.bus_stop;
        ack = ack & a1 & a2;
        tick(3);
    end
    endtask
    task rd(input [7:0] a);
        reg a1;
    begin
        u_ctl.bus_start;
        u_ctl.wbyte(AW, a1);
        u_ctl.wbyte(a, a1);
        u_ctl.bus_start;
        u_ctl.wbyte(AW | 8'h01, ack);
        u_ctl.rbyte(1'b1, rv);
        u_ctl.bus_stop;
    end
    endtask
    task t_powerup;
    begin
        u_ctl.bus_stop;
        por = 1'b1;
        tick(10);
        check({5'h0, mode}, 8'h01);
        check({7'h0, dis}, 8'h00);
        check({7'h0, iface}, 8'h00);
        uvlo = 1'b1;
        wait_mode(3'h2);
        check({5'h0, mode}, 8'h02);
        wait_mode(3'h3);
        check({5'h0, frequency_select_strap_q, sec}, 8'h03);
        check(init_len, 8'h14);
        check({7'h0, iface}, 8'h01);
        check(cfga, 8'h2A);
        check(cfgb, 8'h09);
        check(cfgc, 8'h00);
        check({7'h0, sw}, 8'h00);
        en_ext = 1'b1;
        wait_mode(3'h4);
        check({6'h0, mode == 3'h4, sw}, 8'h03);
    end
    endtask
    task t_address;
    begin
        for (k = 0; k < 2; k = k + 1) begin
            u_ctl.bus_start;
            u_ctl.wbyte(k ? 8'h00 : 8'h82, ack);
            check({7'h0, ack}, 8'h00);
            u_ctl.wbyte(8'h00, rv[0]);
            u_ctl.wbyte(8'h77, rv[0]);
            u_ctl.bus_stop;
            tick(5);
            check(output_voltage_setpoint, 8'h00);
        end
    end
    endtask
    task t_regs;
    begin
        wr(8'h00, 8'h5A);
        check({7'h0, ack}, 8'h01);
        check(output_voltage_setpoint, 8'h5A);
        rd(8'h00);
        check(rv, 8'h5A);
        rd(8'h10);
        check(rv, 8'h00);
        wr(8'h01, 8'h0A);
        tick(5);
        check({5'h0, mode}, 8'h03);
        wr(8'h01, 8'h2A);
        tick(5);
        check({5'h0, mode}, 8'h04);
    end
    endtask
    task t_faults;
    begin
        for (k = 0; k < 2; k = k + 1) begin
            saw_sst = 1'b0;
            if (k == 0) ot = 1'b1;
            else ovlo = 1'b1;
            tick(8);
            check({5'h0, mode}, 8'h03);
            check({7'h0, en_pull}, 8'h01);
            ot = 1'b0;
            ovlo = 1'b0;
            wait_mode(3'h4);
            check({5'h0, mode}, 8'h04);
            tick(1);
            check({7'h0, saw_sst}, 8'h01);
        end
        cl = 1'b1;
        tick(8);
        check({6'h0, en_pull, clamp}, 8'h01);
        cl = 1'b0;
    end
    endtask
    task t_dip;
    begin
        uvlo = 1'b0;
        tick(8);
        check({5'h0, mode}, 8'h01);
        check({7'h0, dis}, 8'h01);
        check(output_voltage_setpoint, 8'h5A);
        saw_init = 1'b0;
        uvlo = 1'b1;
        wait_mode(3'h4);
        check({7'h0, saw_init}, 8'h00);
        por = 1'b0;
        uvlo = 1'b0;
        tick(10);
        check({5'h0, mode}, 8'h00);
        por = 1'b1;
        uvlo = 1'b1;
        wait_mode(3'h2);
        check({5'h0, mode}, 8'h02);
        wait_mode(3'h4);
    end
    endtask
    task t_swreset;
    begin
        wr(8'h00, 8'h5A);
        saw_init = 1'b0;
        wr(8'h01, 8'hAA);
        check({7'h0, saw_init}, 8'h01);
        check(cfga, 8'h2A);
        check(output_voltage_setpoint, 8'h00);
        wr(8'h00, 8'h33);
        check(output_voltage_setpoint, 8'h00);
        tick(1000);
        rd(8'h01);
        check(rv, 8'h2A);
        wr(8'h00, 8'h33);
        check(output_voltage_setpoint, 8'h33);
    end
    endtask
    task final_report;
    begin
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // About five times the expected run, well under the cycle budget.
    initial begin
        #400000;
        failures = failures + 1;
        final_report;
    end
    initial begin
        tick(2);
        srst_in = 1'b0;
        t_powerup;
        t_address;
        t_regs;
        t_faults;
        t_dip;
        t_swreset;
        final_report;
    end
endmodule
